// >>> sim/i2c_host_model.sv
// Bus host model driving clock and data of the target
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // Clock
    input wire logic clk_i,
    // Resolved data line
    input wire logic sda_i,
    // Pins, data high means released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic quarter();
        repeat (2) @(negedge clk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        quarter();
        scl_o = 1'b1;
        quarter();
        r = sda_i;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask
    task automatic start();
        quarter();
        sda_o = 1'b0;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_o = 1'b0;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_o = 1'b1;
        repeat (4) quarter();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// >>> sim/nvm_access_chk.sv
// Port assertions for the configuration space target
`timescale 1ns/1ps
`default_nettype none
module nvm_access_chk #(
    parameter int LOAD_CYCLES = 20,
    parameter int COMMIT_CYCLES = 50
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // Bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_OE_O,
    // Status
    input wire logic PROG_MODE_O,
    input wire logic BUSY_O,
    input wire logic [1:0] HUM_RES_O,
    input wire logic [1:0] TEMP_RES_O,
    input wire logic [3:0] HUM_BITS_O,
    input wire logic [3:0] TEMP_BITS_O
);
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);
    logic [19:0] busy_len;
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            busy_len <= 20'h0;
        end else begin
            busy_len <= BUSY_O ? busy_len + 20'h1 : 20'h0;
        end
    end
    sequence busy_end;
        !BUSY_O && ($past(BUSY_O) || $past(BUSY_O, 2));
    endsequence
    chk_reset_values: assert property ($fell(RESET_I) |-> HUM_RES_O == 2'h3
        && TEMP_RES_O == 2'h3 && !PROG_MODE_O && !BUSY_O) else $error("reset values");
    chk_hum_decode: assert property (HUM_BITS_O == 4'h8 + {1'b0, HUM_RES_O, 1'b0})
        else $error("humidity decode");
    chk_temp_decode: assert property (TEMP_BITS_O == 4'h8 + {1'b0, TEMP_RES_O, 1'b0})
        else $error("temperature decode");
    chk_hum_commit: assert property ($changed(HUM_RES_O) |-> busy_end)
        else $error("humidity change outside commit");
    chk_temp_commit: assert property ($changed(TEMP_RES_O) |-> busy_end)
        else $error("temperature change outside commit");
    chk_res_independent: assert property (!($changed(HUM_RES_O) && $changed(TEMP_RES_O)))
        else $error("both resolutions changed");
    chk_busy_length: assert property ($fell(BUSY_O) |-> (busy_len - LOAD_CYCLES) <= 1
        || (busy_len - COMMIT_CYCLES) <= 1) else $error("busy length");
    chk_busy_quiet: assert property (BUSY_O |-> !$rose(SDA_OE_O))
        else $error("answer while busy");
    chk_mode_at_stop: assert property ($changed(PROG_MODE_O) |-> SCL_I && SDA_I)
        else $error("mode change outside stop");
endmodule
bind nvm_access nvm_access_chk #(
    .LOAD_CYCLES(LOAD_CYCLES),
    .COMMIT_CYCLES(COMMIT_CYCLES)
) nvm_access_chk_i (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_OE_O(SDA_OE_O), .PROG_MODE_O(PROG_MODE_O), .BUSY_O(BUSY_O),
    .HUM_RES_O(HUM_RES_O), .TEMP_RES_O(TEMP_RES_O), .HUM_BITS_O(HUM_BITS_O),
    .TEMP_BITS_O(TEMP_BITS_O)
);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the configuration space target
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int WIN = 2000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_drv, sda_oe, prog, busy;
    logic sda_val;
    logic [1:0] hres, tres;
    logic [3:0] hbits, tbits;
    logic [15:0] sh [2] = '{nvm_access_pkg::HUM_RES_RESET, nvm_access_pkg::TEMP_RES_RESET};
    int fail_count = 0;
    int samples_checked = 0;
    wire logic sda = sda_drv & (sda_oe ? sda_val : 1'b1);
    nvm_access #(.LOAD_CYCLES(20), .COMMIT_CYCLES(400), .WINDOW_CYCLES(WIN)) nvm_access_i (
        .SYS_CLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_val),
        .SDA_OE_O(sda_oe), .PROG_MODE_O(prog), .BUSY_O(busy), .HUM_RES_O(hres),
        .TEMP_RES_O(tres), .HUM_BITS_O(hbits), .TEMP_BITS_O(tbits));
    i2c_host_model i2c_host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_drv));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] b[$], output logic ok);
        logic k;
        i2c_host_model_i.start();
        i2c_host_model_i.wbyte({nvm_access_pkg::TARGET_ADDR, 1'b0}, ok);
        foreach (b[i]) begin
            if (ok) begin
                i2c_host_model_i.wbyte(b[i], k);
                cmp("data_ack", 1'b1, k);
            end
        end
        i2c_host_model_i.stop();
    endtask
    task automatic idle();
        int t = 0;
        while (busy !== 1'b0 && t < 2000) begin
            @(negedge clk);
            t++;
        end
        cmp("busy", 1'b0, busy);
    endtask
    task automatic t_read(input logic [7:0] a, input logic [15:0] e);
        logic ok;
        logic [15:0] w;
        wr('{a}, ok);
        idle();
        i2c_host_model_i.start();
        i2c_host_model_i.wbyte({nvm_access_pkg::TARGET_ADDR, 1'b1}, ok);
        cmp("read_ack", 1'b1, ok);
        i2c_host_model_i.rbyte(1'b0, w[15:8]);
        i2c_host_model_i.rbyte(1'b1, w[7:0]);
        i2c_host_model_i.stop();
        cmp("word", e, w);
    endtask
    task automatic t_reset();
        cmp("hres", 2'h3, hres);
        cmp("tres", 2'h3, tres);
        cmp("hbits", 4'he, hbits);
        cmp("tbits", 4'he, tbits);
        cmp("prog", 1'b0, prog);
        cmp("sda_o", 1'b0, sda_val);
    endtask
    task automatic t_enter(input logic e);
        logic ok;
        wr('{nvm_access_pkg::CMD_ENTER_PROG, nvm_access_pkg::CMD_FILL}, ok);
        idle();
        cmp("prog", e, prog);
    endtask
    task automatic t_rmw(input logic t, input logic [1:0] c);
        logic ok;
        logic [7:0] a;
        a = t ? nvm_access_pkg::ADDR_TEMP_RES_READ : nvm_access_pkg::ADDR_HUM_RES_READ;
        t_read(a, sh[t]);
        sh[t][11:10] = c;
        a = t ? nvm_access_pkg::ADDR_TEMP_RES_WRITE : nvm_access_pkg::ADDR_HUM_RES_WRITE;
        wr('{a, sh[t][15:8], sh[t][7:0]}, ok);
        cmp("write_ack", 1'b1, ok);
        cmp("busy", 1'b1, busy);
        idle();
        cmp("hres", sh[0][11:10], hres);
        cmp("tres", sh[1][11:10], tres);
        cmp("hbits", 16'(8 + 2 * sh[0][11:10]), hbits);
        cmp("tbits", 16'(8 + 2 * sh[1][11:10]), tbits);
    endtask
    task automatic t_busy();
        logic ok;
        wr('{nvm_access_pkg::ADDR_HUM_RES_WRITE, sh[0][15:8], sh[0][7:0]}, ok);
        wr('{nvm_access_pkg::ADDR_HUM_RES_READ}, ok);
        cmp("ack", 1'b0, ok);
        idle();
    endtask
    task automatic t_leave();
        logic ok;
        wr('{nvm_access_pkg::CMD_LEAVE_PROG, 8'h00, 8'h00}, ok);
        idle();
        cmp("prog", 1'b0, prog);
        wr('{nvm_access_pkg::ADDR_HUM_RES_WRITE, 8'h00, 8'h00}, ok);
        idle();
        cmp("hres", sh[0][11:10], hres);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_enter(1'b1);
        t_read(nvm_access_pkg::ADDR_ID_UPPER, nvm_access_pkg::ID_RESET[31:16]);
        t_read(nvm_access_pkg::ADDR_ID_LOWER, nvm_access_pkg::ID_RESET[15:0]);
        for (int c = 0; c < 4; c++) begin
            t_rmw(1'b0, 2'(c));
            t_rmw(1'b1, 2'(3 - c));
        end
        t_busy();
        t_leave();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        repeat (WIN) @(negedge clk);
        t_enter(1'b0);
        summarize();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire

// >>> src/bus_pin_sync.sv
// Two-flop synchronisers and edge, start and stop detection for the bus pins
`timescale 1ns/1ps
`default_nettype none
module bus_pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Raw pins
    input wire logic scl_i,
    input wire logic sda_i,
    // Synchronised level and events
    output logic sda_o,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_i};
            sda_meta <= {sda_meta[0], sda_i};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_s = scl_meta[1];
    assign sda_s = sda_meta[1];
    assign sda_o = sda_s;
    assign scl_rise_o = scl_s & ~scl_d;
    assign scl_fall_o = ~scl_s & scl_d;
    assign start_o = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_o = scl_s & scl_d & ~sda_d & sda_s;
endmodule
`default_nettype wire

// >>> src/nvm_access.sv
// Bus target for the resolution and identifier configuration space
`timescale 1ns/1ps
`default_nettype none
module nvm_access #(
    parameter logic [6:0] TARGET_ADDR = nvm_access_pkg::TARGET_ADDR,
    parameter int LOAD_CYCLES = nvm_access_pkg::LOAD_CYCLES,
    parameter int COMMIT_CYCLES = nvm_access_pkg::COMMIT_CYCLES,
    parameter int WINDOW_CYCLES = nvm_access_pkg::WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // Bus pins, open drain data
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Status and configuration
    output logic PROG_MODE_O,
    output logic BUSY_O,
    output logic [1:0] HUM_RES_O,
    output logic [1:0] TEMP_RES_O,
    output logic [3:0] HUM_BITS_O,
    output logic [3:0] TEMP_BITS_O
);
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} bus_state_t;
    typedef enum {ACT_NONE, ACT_LOAD, ACT_COMMIT} action_t;

    localparam int TW = nvm_access_pkg::TIMER_WIDTH;

    function automatic logic [3:0] res_bits(input logic [1:0] field);
        case (field)
            nvm_access_pkg::RES_8: res_bits = 4'h8;
            nvm_access_pkg::RES_10: res_bits = 4'ha;
            nvm_access_pkg::RES_12: res_bits = 4'hc;
            default: res_bits = 4'he;
        endcase
    endfunction

    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    bus_state_t state;
    action_t action;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic master_ack;
    logic [1:0] rx_cnt;
    logic [7:0] rx_byte [3];
    logic [15:0] hum_reg;
    logic [15:0] temp_reg;
    logic [15:0] out_word;
    logic [15:0] pend_word;
    logic [7:0] pend_addr;
    logic tx_half;
    logic prog;
    logic [TW-1:0] busy_cnt;
    logic [TW-1:0] window_cnt;
    logic window_open;
    logic sda_oe;

    bus_pin_sync u_sync (
        .clk_i(SYS_CLK_I),
        .reset_i(RESET_I),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .sda_o(sda_s),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(start_ev),
        .stop_o(stop_ev)
    );

    // Decoding of a finished write transaction
    wire busy = (action != ACT_NONE);
    wire addr_match = (shreg[7:1] == TARGET_ADDR) && !busy;
    wire wr_done = stop_ev && !rw && (state != ST_IDLE);
    wire is_enter = (rx_cnt >= 2'd2) && (rx_byte[0] == nvm_access_pkg::CMD_ENTER_PROG) &&
        (rx_byte[1] == nvm_access_pkg::CMD_FILL);
    wire is_leave = (rx_cnt != 2'd0) && (rx_byte[0] == nvm_access_pkg::CMD_LEAVE_PROG);
    wire is_read_addr = (rx_cnt != 2'd0) &&
        ((rx_byte[0] == nvm_access_pkg::ADDR_HUM_RES_READ) ||
         (rx_byte[0] == nvm_access_pkg::ADDR_TEMP_RES_READ) ||
         (rx_byte[0] == nvm_access_pkg::ADDR_ID_UPPER) ||
         (rx_byte[0] == nvm_access_pkg::ADDR_ID_LOWER));
    wire is_write_addr = (rx_cnt == 2'd3) &&
        ((rx_byte[0] == nvm_access_pkg::ADDR_HUM_RES_WRITE) ||
         (rx_byte[0] == nvm_access_pkg::ADDR_TEMP_RES_WRITE));
    wire [7:0] tx_byte = tx_half ? out_word[7:0] : out_word[15:8];
    wire timer_done = busy && (busy_cnt == '0);

    // Word selected by a read address
    logic [15:0] read_word;
    always_comb begin
        case (pend_addr)
            nvm_access_pkg::ADDR_HUM_RES_READ: read_word = hum_reg;
            nvm_access_pkg::ADDR_TEMP_RES_READ: read_word = temp_reg;
            nvm_access_pkg::ADDR_ID_UPPER: read_word = nvm_access_pkg::ID_RESET[31:16];
            nvm_access_pkg::ADDR_ID_LOWER: read_word = nvm_access_pkg::ID_RESET[15:0];
            default: read_word = 16'hffff;
        endcase
    end

    // Power-up window for entering program mode
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            window_cnt <= '0;
        end else if (window_open) begin
            window_cnt <= window_cnt + 1'b1;
        end
    end
    assign window_open = (window_cnt < TW'(WINDOW_CYCLES));

    // Bus byte engine
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            master_ack <= 1'b0;
            rx_cnt <= 2'h0;
            rx_byte <= '{default: 8'h00};
            tx_half <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_ev) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            rx_cnt <= 2'h0;
            rw <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_ev) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (state)
                ST_ADDR, ST_RX: begin
                    shreg <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                ST_TX: bit_cnt <= bit_cnt + 4'h1;
                ST_TX_ACK: master_ack <= ~sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        if (addr_match) begin
                            state <= ST_ADDR_ACK;
                            rw <= shreg[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (rw) begin
                        state <= ST_TX;
                        tx_half <= 1'b0;
                        shreg <= out_word[15:8];
                        sda_oe <= ~out_word[15];
                    end else begin
                        state <= ST_RX;
                        sda_oe <= 1'b0;
                    end
                end
                ST_RX: begin
                    if (bit_cnt == 4'h8) begin
                        state <= ST_RX_ACK;
                        sda_oe <= 1'b1;
                        if (rx_cnt != 2'h3) begin
                            rx_byte[rx_cnt] <= shreg;
                            rx_cnt <= rx_cnt + 2'h1;
                        end
                    end
                end
                ST_RX_ACK: begin
                    state <= ST_RX;
                    bit_cnt <= 4'h0;
                    sda_oe <= 1'b0;
                end
                ST_TX: begin
                    if (bit_cnt == 4'h8) begin
                        state <= ST_TX_ACK;
                        sda_oe <= 1'b0;
                        tx_half <= ~tx_half;
                    end else begin
                        shreg <= {shreg[6:0], 1'b1};
                        sda_oe <= ~shreg[6];
                    end
                end
                ST_TX_ACK: begin
                    if (master_ack) begin
                        state <= ST_TX;
                        bit_cnt <= 4'h0;
                        shreg <= tx_byte;
                        sda_oe <= ~tx_byte[7];
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Mode, load and commit sequencing
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            prog <= 1'b0;
            action <= ACT_NONE;
            busy_cnt <= '0;
            pend_addr <= 8'h00;
            pend_word <= 16'h0000;
            out_word <= 16'hffff;
            hum_reg <= nvm_access_pkg::HUM_RES_RESET;
            temp_reg <= nvm_access_pkg::TEMP_RES_RESET;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 1'b1;
            if (timer_done) begin
                action <= ACT_NONE;
                if (action == ACT_LOAD) begin
                    out_word <= read_word;
                end else if (pend_addr == nvm_access_pkg::ADDR_HUM_RES_WRITE) begin
                    hum_reg <= pend_word;
                end else begin
                    temp_reg <= pend_word;
                end
            end
        end else if (wr_done) begin
            if (is_enter && window_open && !prog) begin
                prog <= 1'b1;
                action <= ACT_LOAD;
                busy_cnt <= TW'(LOAD_CYCLES - 1);
                pend_addr <= 8'h00;
            end else if (is_leave && prog) begin
                prog <= 1'b0;
            end else if (is_read_addr && prog) begin
                action <= ACT_LOAD;
                busy_cnt <= TW'(LOAD_CYCLES - 1);
                pend_addr <= rx_byte[0];
            end else if (is_write_addr && prog) begin
                action <= ACT_COMMIT;
                busy_cnt <= TW'(COMMIT_CYCLES - 1);
                pend_addr <= rx_byte[0];
                pend_word <= {rx_byte[1], rx_byte[2]};
            end
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;
    assign PROG_MODE_O = prog;
    assign BUSY_O = busy;
    assign HUM_RES_O = hum_reg[nvm_access_pkg::RES_MSB:nvm_access_pkg::RES_LSB];
    assign TEMP_RES_O = temp_reg[nvm_access_pkg::RES_MSB:nvm_access_pkg::RES_LSB];
    assign HUM_BITS_O = res_bits(HUM_RES_O);
    assign TEMP_BITS_O = res_bits(TEMP_RES_O);
endmodule
`default_nettype wire

// >>> src/nvm_access_pkg.sv
// Constants for the sensor resolution and identifier configuration space
package nvm_access_pkg;
    // Register addresses, the first byte of a write transaction
    localparam logic [7:0] ADDR_HUM_RES_READ = 8'h06;
    localparam logic [7:0] ADDR_TEMP_RES_READ = 8'h11;
    localparam logic [7:0] ADDR_ID_UPPER = 8'h1e;
    localparam logic [7:0] ADDR_ID_LOWER = 8'h1f;
    localparam logic [7:0] ADDR_HUM_RES_WRITE = 8'h46;
    localparam logic [7:0] ADDR_TEMP_RES_WRITE = 8'h51;
    // Mode commands
    localparam logic [7:0] CMD_ENTER_PROG = 8'ha0;
    localparam logic [7:0] CMD_LEAVE_PROG = 8'h80;
    localparam logic [7:0] CMD_FILL = 8'h00;
    // Resolution field of a 16-bit configuration register
    localparam int RES_LSB = 10;
    localparam int RES_MSB = 11;
    localparam int REG_WIDTH = 16;
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] RES_14 = 2'h3;
    // Factory contents: resolution field selects 14-bit, other bits arbitrary
    localparam logic [15:0] HUM_RES_RESET = 16'h0c00;
    localparam logic [15:0] TEMP_RES_RESET = 16'h0c00;
    // Identifier value, arbitrary
    localparam logic [31:0] ID_RESET = 32'h1234_5678;
    // Target address on the bus, arbitrary
    localparam logic [6:0] TARGET_ADDR = 7'h44;
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int LOAD_TIME_US = 120;
    localparam int COMMIT_TIME_MS = 14;
    localparam int PROG_WINDOW_MS = 10;
    localparam int LOAD_CYCLES = LOAD_TIME_US * CLK_MHZ;
    localparam int COMMIT_CYCLES = COMMIT_TIME_MS * 1000 * CLK_MHZ;
    localparam int WINDOW_CYCLES = PROG_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int TIMER_WIDTH = 20;
endpackage
